// ===== logic/mmutb_top.sv
// Translation buffers: variable-page and fixed-page arrays, SRAM precedence.
// Assumes the core presents one access per cycle and issues write-entry
// as a one-cycle strobe after loading the assist registers.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Sixteen fully associative variable entries, pages 4 Kbyte to 256 Mbyte.
// - 256-entry two-way array of fixed 4 Kbyte pages.
// - After reset one valid entry maps only the top 4 Kbytes.
// - Write-entry copies assist register fields into the selected entry.
// - Entry-select bits 44-47 pick the variable entry written.
// - Size bits 52-55 set page size; larger regions use several entries.
// - Effective page bits 32-51 give the matched page base.
// - Bit 60 of effective page register marks page cache inhibited.
// - Real page bits 32-51 give output page; permissions alongside.
// - Assist registers are 64 bits, all written; fields sit in low half, bits 32-63.
// - One flat 32-bit address space holds memory and config registers.
// - Enabled SRAM window beats every mapping but config space for core and snooped I/O.
// - Non-snooped I/O in SRAM/window overlap goes to local window.
// - Valid bit with size code 8 gives a 64 Mbyte page.
// - Valid bit with size code 9 gives a 256 Mbyte page.
module mmutb_top
    import mmutb_pkg::*;
(
    // Clock and reset
    input  wire  logic        REF_CLK,
    input  wire  logic        RST,
    // Assist register port
    input  wire  logic        AR_WE,
    input  wire  logic [1:0]  AR_SEL,
    input  wire  logic [63:0] AR_WDATA,
    output var   logic [63:0] AR_RDATA,
    input  wire  logic        WRITE_ENTRY,
    // Access from the core
    input  wire  logic        ACC_VALID,
    input  wire  logic [1:0]  ACC_KIND,
    input  wire  logic [31:0] ACC_EADDR,
    // SRAM and window configuration
    input  wire  logic        SRAM_EN,
    input  wire  logic        SRAM_256K,
    input  wire  logic [31:0] SRAM_BASE,
    input  wire  logic        LAW_HIT,
    input  wire  logic [31:0] CFG_BASE,
    // Translated result
    output var   logic        RES_VALID,
    output var   logic        RES_MISS,
    output var   logic [31:0] RES_RADDR,
    output var   logic        RES_INHIBIT,
    output var   logic [5:0]  RES_PERM,
    output var   logic [1:0]  RES_ROUTE
);
    // ------------------------------------------------------------
    // Assist registers
    // ------------------------------------------------------------
    logic [63:0] assist [4];
    logic [63:0] next_assist [4];

    // Whole 64-bit word written; low half is what the arrays use
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_assist[i] = assist[i];
        end
        if (AR_WE) begin
            next_assist[AR_SEL] = AR_WDATA;
        end
    end

    always_ff @(posedge REF_CLK) begin
        for (int i = 0; i < 4; i++) begin
            if (RST) assist[i] <= 64'h0000_0000_0000_0000;
            else     assist[i] <= next_assist[i];
        end
    end

    assign AR_RDATA = assist[AR_SEL];

    // Decoded assist fields
    logic [3:0]  w_sel;
    logic        w_fix;
    logic        w_valid;
    logic [3:0]  w_size;
    logic [19:0] w_epn;
    logic        w_inh;
    logic [19:0] w_rpn;
    logic [5:0]  w_perm;
    assign w_sel   = assist[0][SEL_MSB:SEL_LSB];
    assign w_fix   = ~assist[0][TLBSEL_BIT];
    assign w_valid = assist[1][VALID_BIT];
    assign w_size  = assist[1][SIZE_MSB:SIZE_LSB];
    assign w_epn   = assist[2][PAGE_MSB:PAGE_LSB];
    assign w_inh   = assist[2][INHIBIT_BIT];
    assign w_rpn   = assist[3][PAGE_MSB:PAGE_LSB];
    assign w_perm  = assist[3][PERM_MSB:PERM_LSB];

    // ------------------------------------------------------------
    // Variable-page array
    // ------------------------------------------------------------
    logic        v_valid [VAR_ENTRIES];
    logic [3:0]  v_size  [VAR_ENTRIES];
    logic [19:0] v_epn   [VAR_ENTRIES];
    logic [19:0] v_rpn   [VAR_ENTRIES];
    logic        v_inh   [VAR_ENTRIES];
    logic [5:0]  v_perm  [VAR_ENTRIES];

    // Entry 0 holds the boot page after reset; written only on request
    always_ff @(posedge REF_CLK) begin
        for (int i = 0; i < VAR_ENTRIES; i++) begin
            if (RST) begin
                v_valid[i] <= (i == 0);
                v_size[i]  <= SIZE_4K;
                v_epn[i]   <= BOOT_PAGE;
                v_rpn[i]   <= BOOT_PAGE;
                v_inh[i]   <= 1'b1;
                v_perm[i]  <= PERM_ALL;
            end else if (WRITE_ENTRY && !w_fix && w_sel == 4'(i)) begin
                v_valid[i] <= w_valid;
                v_size[i]  <= w_size;
                v_epn[i]   <= w_epn;
                v_rpn[i]   <= w_rpn;
                v_inh[i]   <= w_inh;
                v_perm[i]  <= w_perm;
            end
        end
    end

    // Page mask from size code: 4 Kbyte times 4 to the (code-1)
    function automatic logic [19:0] page_mask(input logic [3:0] code);
        logic [4:0] bits;
        bits = (code == 4'h0) ? 5'd0 :
               (code > SIZE_256M) ? 5'd16 : 5'(2 * (code - 4'h1));
        page_mask = 20'hF_FFFF << bits;
    endfunction

    // ------------------------------------------------------------
    // Fixed-page array, two ways, replaced round robin per set
    // ------------------------------------------------------------
    logic        f_valid [2][FIX_SETS];
    logic [12:0] f_tag   [2][FIX_SETS];
    logic [19:0] f_rpn   [2][FIX_SETS];
    logic        f_inh   [2][FIX_SETS];
    logic [5:0]  f_perm  [2][FIX_SETS];
    logic        f_victim [FIX_SETS];
    logic [6:0]  w_set;
    assign w_set = w_epn[6:0];

    // Writes land in the set picked by the page's low bits
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            for (int s = 0; s < FIX_SETS; s++) begin
                f_valid[0][s] <= 1'b0;
                f_valid[1][s] <= 1'b0;
                f_victim[s]   <= 1'b0;
            end
        end else if (WRITE_ENTRY && w_fix) begin
            f_valid[f_victim[w_set]][w_set] <= w_valid;
            f_tag[f_victim[w_set]][w_set]   <= w_epn[19:7];
            f_rpn[f_victim[w_set]][w_set]   <= w_rpn;
            f_inh[f_victim[w_set]][w_set]   <= w_inh;
            f_perm[f_victim[w_set]][w_set]  <= w_perm;
            f_victim[w_set] <= ~f_victim[w_set];
        end
    end

    // ------------------------------------------------------------
    // Lookup and routing
    // ------------------------------------------------------------
    logic        next_res_valid;
    logic        next_miss;
    logic [31:0] next_raddr;
    logic        next_inh;
    logic [5:0]  next_perm;
    mmutb_route_e next_route;

    always_comb begin
        logic [19:0] pg;
        logic [19:0] m;
        logic [6:0]  st;
        logic        hit;
        logic        in_sram;
        logic [31:0] smask;
        pg = ACC_EADDR[31:12];
        m = 20'h0_0000;
        st = ACC_EADDR[FIX_IDX_MSB:FIX_IDX_LSB];
        hit = 1'b0;
        next_raddr = 32'h0000_0000;
        next_inh = 1'b0;
        next_perm = 6'h00;
        in_sram = 1'b0;
        smask = 32'h0000_0000;
        // Fully associative search; lowest entry wins on overlap
        for (int i = VAR_ENTRIES - 1; i >= 0; i--) begin
            m = page_mask(v_size[i]);
            if (v_valid[i] && ((pg & m) == (v_epn[i] & m))) begin
                hit = 1'b1;
                next_raddr = {(v_rpn[i] & m) | (pg & ~m), ACC_EADDR[11:0]};
                next_inh = v_inh[i];
                next_perm = v_perm[i];
            end
        end
        for (int w = 0; w < 2; w++) begin
            if (!hit && f_valid[w][st] && f_tag[w][st] == pg[19:7]) begin
                hit = 1'b1;
                next_raddr = {f_rpn[w][st], ACC_EADDR[11:0]};
                next_inh = f_inh[w][st];
                next_perm = f_perm[w][st];
            end
        end
        next_res_valid = ACC_VALID && hit;
        next_miss = ACC_VALID && !hit;
        if (!hit) begin
            next_raddr = 32'h0000_0000;
        end
        // One flat 32-bit space decides the target
        smask = SRAM_256K ? SRAM_256K_MASK : SRAM_128K_MASK;
        in_sram = SRAM_EN && ((next_raddr & smask) == (SRAM_BASE & smask));
        if (!hit) begin
            next_route = MMUTB_TO_NONE;
        end else if ((next_raddr & CFG_SPACE_MASK) ==
                     (CFG_BASE & CFG_SPACE_MASK)) begin
            next_route = MMUTB_TO_CFG;   // checked first, so it beats SRAM on overlap
        end else if (in_sram && ACC_KIND != MMUTB_IO_PLAIN) begin
            next_route = MMUTB_TO_SRAM;
        end else if (LAW_HIT) begin
            next_route = MMUTB_TO_LAW;
        end else begin
            next_route = in_sram ? MMUTB_TO_NONE : MMUTB_TO_LAW;
        end
    end

    // Registered result, one cycle after the access
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RES_VALID   <= 1'b0;
            RES_MISS    <= 1'b0;
            RES_RADDR   <= 32'h0000_0000;
            RES_INHIBIT <= 1'b0;
            RES_PERM    <= 6'h00;
            RES_ROUTE   <= MMUTB_TO_NONE;
        end else begin
            RES_VALID   <= next_res_valid;
            RES_MISS    <= next_miss;
            RES_RADDR   <= next_raddr;
            RES_INHIBIT <= next_inh;
            RES_PERM    <= next_perm;
            RES_ROUTE   <= next_route;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    // Every access gets exactly one kind of answer, one cycle later
    miss_excl_a: assert property (!(RES_MISS && RES_VALID))
        else $error("miss and valid together");
    miss_addr_a: assert property (
        RES_MISS |-> RES_RADDR == 32'h0000_0000)
        else $error("miss carries an address");
    access_answer_a: assert property (
        ACC_VALID |=> RES_VALID || RES_MISS)
        else $error("access got no answer");
    idle_quiet_a: assert property (
        !ACC_VALID |=> !RES_VALID && !RES_MISS)
        else $error("answer without access");
    // Only the boot page answers right after a reset
    boot_page_a: assert property (
        $rose(!RST) && ACC_VALID && ACC_EADDR[31:12] == BOOT_PAGE
        |=> RES_VALID)
        else $error("boot page not mapped");
    boot_only_a: assert property (
        $fell(RST) && ACC_VALID && ACC_EADDR[31:12] != BOOT_PAGE
        |=> RES_MISS)
        else $error("non-boot page mapped after reset");
    // Reset itself is watched, so this one is never disabled
    boot_reset_a: assert property (disable iff (1'b0)
        RST |=> v_valid[0] && !v_valid[1] && !v_valid[15] &&
        v_epn[0] == BOOT_PAGE)
        else $error("boot entry not restored by reset");
    // Written entry holds the assist fields from the next edge on
    var_write_a: assert property (
        WRITE_ENTRY && !w_fix && w_sel == 4'h1 |=>
        v_valid[1] == $past(w_valid) && v_size[1] == $past(w_size) &&
        v_epn[1] == $past(w_epn) && v_rpn[1] == $past(w_rpn))
        else $error("variable entry not written");
    fix_victim_a: assert property (
        WRITE_ENTRY && w_fix |=>
        f_victim[$past(w_set)] != $past(f_victim[w_set]))
        else $error("fixed array victim did not rotate");
    // Routing seen on the registered outputs
    plain_io_a: assert property (
        ACC_VALID && ACC_KIND == MMUTB_IO_PLAIN
        |=> RES_ROUTE != MMUTB_TO_SRAM)
        else $error("plain I/O routed to SRAM");
    sram_cpu_a: assert property (
        RES_ROUTE == MMUTB_TO_SRAM |->
        RES_VALID && $past(SRAM_EN) && $past(ACC_KIND) != MMUTB_IO_PLAIN)
        else $error("SRAM route for wrong kind");
    route_none_a: assert property (
        RES_MISS |-> RES_ROUTE == MMUTB_TO_NONE)
        else $error("miss routed");

    cov_hit_c:  cover property (RES_VALID && RES_ROUTE == MMUTB_TO_LAW);
    cov_sram_c: cover property (RES_ROUTE == MMUTB_TO_SRAM);
    cov_miss_c: cover property (RES_MISS);
    cov_fix_c:  cover property (WRITE_ENTRY && w_fix ##1 ACC_VALID);
    cov_boot_c: cover property ($fell(RST) ##1 RES_MISS);
endmodule

`default_nettype wire

// ===== logic/mmutb_pkg.sv
// Constants and types for the translation buffer block.
// Assumes bit numbering of assist registers is left to right, bit 32..63.
package mmutb_pkg;
    // ------------------------------------------------------------
    // Assist register fields (bit n maps to vector index 63-n)
    // ------------------------------------------------------------
    localparam int SEL_LSB      = 63 - 47;  // entry select, bits 44-47
    localparam int SEL_MSB      = 63 - 44;
    localparam int TLBSEL_BIT   = 63 - 35;  // array select in entry select
    localparam int VALID_BIT    = 63 - 32;  // valid, size control
    localparam int SIZE_LSB     = 63 - 55;  // page size, bits 52-55
    localparam int SIZE_MSB     = 63 - 52;
    localparam int PAGE_LSB     = 63 - 51;  // page number, bits 32-51
    localparam int PAGE_MSB     = 63 - 32;
    localparam int INHIBIT_BIT  = 63 - 60;  // cache inhibit
    localparam int PERM_LSB     = 63 - 63;  // permission bits 58-63
    localparam int PERM_MSB     = 63 - 58;
    localparam int FIX_IDX_LSB  = 12;       // set index from address
    localparam int FIX_IDX_MSB  = 18;

    // ------------------------------------------------------------
    // Array geometry and page size codes
    // ------------------------------------------------------------
    localparam int VAR_ENTRIES  = 16;
    localparam int FIX_SETS     = 128;      // 256 entries, two ways
    localparam logic [3:0] SIZE_4K   = 4'h1;
    localparam logic [3:0] SIZE_64M  = 4'h8;
    localparam logic [3:0] SIZE_256M = 4'h9;

    // ------------------------------------------------------------
    // Reset values and address masks
    // ------------------------------------------------------------
    localparam logic [19:0] BOOT_PAGE   = 20'hF_FFFF;
    localparam logic [5:0]  PERM_ALL    = 6'h3F;
    localparam logic [31:0] SRAM_128K_MASK = 32'hFFFE_0000;
    localparam logic [31:0] SRAM_256K_MASK = 32'hFFFC_0000;
    localparam logic [31:0] CFG_SPACE_MASK = 32'hFFF0_0000;

    // Access kinds
    typedef enum logic [1:0] {
        MMUTB_CPU      = 2'b00,
        MMUTB_IO_SNOOP = 2'b01,
        MMUTB_IO_PLAIN = 2'b10
    } mmutb_kind_e;

    // Route of a translated access
    typedef enum logic [1:0] {
        MMUTB_TO_NONE = 2'b00,
        MMUTB_TO_SRAM = 2'b01,
        MMUTB_TO_LAW  = 2'b10,
        MMUTB_TO_CFG  = 2'b11
    } mmutb_route_e;
endpackage

// ===== dv/mmutb_core_model.sv
// Core model: presents one access per cycle to the translation block.
// Assumes the bench sets go, kind and addr just after a falling edge.
`timescale 1ns/1ps
`default_nettype none
module mmutb_core_model (
    // Request from the bench
    input  wire logic        go,
    input  wire logic [1:0]  kind,
    input  wire logic [31:0] addr,
    // Access towards the block
    output logic             acc_valid,
    output logic [1:0]       acc_kind,
    output logic [31:0]      acc_eaddr
);
    // Idle cycles show inverted values so stale ones never look valid
    assign acc_valid = go;
    assign acc_kind  = go ? kind : ~kind;
    assign acc_eaddr = go ? addr : ~addr;
endmodule
`default_nettype wire

// ===== dv/mmutb_top_tb_top.sv
// Bench: loads assist registers, writes entries, checks translations.
// Assumes results follow each access by one cycle, in order.
`timescale 1ns/1ps
`default_nettype none
module mmutb_top_tb_top
    import mmutb_pkg::*;
;
    // ------------------------------------------------------------
    // Signals and scoreboard
    // ------------------------------------------------------------
    typedef struct packed {
        logic hit; logic miss; logic [31:0] ra;
        logic inh; logic [5:0] perm; logic [1:0] route;
    } mmutb_exp_s;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ar_we = 1'b0, wr_entry = 1'b0, go = 1'b0;
    logic [1:0]  ar_sel = 2'h0, kind = 2'h0;
    logic [63:0] ar_wdata = 64'h0000_0000_0000_0000;
    logic [31:0] addr = 32'h0000_0000, cfg_base = 32'h8000_0000;
    logic [31:0] sram_base = 32'h0000_0000;
    logic        sram_en = 1'b0, sram_256k = 1'b0, law_hit = 1'b1;
    logic [63:0] ar_rdata;
    logic        acc_valid, res_valid, res_miss, res_inh;
    logic [1:0]  acc_kind, res_route;
    logic [31:0] acc_eaddr, res_raddr;
    logic [5:0]  res_perm;
    mmutb_exp_s  q [$];
    int          failures = 0, n_tests = 0;
    integer      seed = 32'h0000_f7b6;

    always #20 clk = ~clk;

    mmutb_core_model i_mmutb_core_model (.go(go), .kind(kind),
        .addr(addr), .acc_valid(acc_valid), .acc_kind(acc_kind),
        .acc_eaddr(acc_eaddr));
    mmutb_top i_mmutb_top (.REF_CLK(clk), .RST(rst), .AR_WE(ar_we),
        .AR_SEL(ar_sel), .AR_WDATA(ar_wdata), .AR_RDATA(ar_rdata),
        .WRITE_ENTRY(wr_entry), .ACC_VALID(acc_valid),
        .ACC_KIND(acc_kind), .ACC_EADDR(acc_eaddr), .SRAM_EN(sram_en),
        .SRAM_256K(sram_256k), .SRAM_BASE(sram_base),
        .LAW_HIT(law_hit), .CFG_BASE(cfg_base), .RES_VALID(res_valid),
        .RES_MISS(res_miss), .RES_RADDR(res_raddr),
        .RES_INHIBIT(res_inh), .RES_PERM(res_perm),
        .RES_ROUTE(res_route));

    // ------------------------------------------------------------
    // Compare, drive and closing tasks
    // ------------------------------------------------------------
    task automatic cmp_res(input mmutb_exp_s e, input mmutb_exp_s g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask
    task automatic cmp_reg(input logic [63:0] e, input logic [63:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask
    // One access per call; go stays high so calls run back to back
    task automatic acc(input logic m, input logic [1:0] k,
        input logic [31:0] a, input logic [31:0] ra, input logic i,
        input logic [5:0] p, input logic [1:0] r);
        q.push_back('{~m, m, m ? 32'h0 : ra, m ? 1'b0 : i,
            m ? 6'h0 : p, m ? 2'h0 : r});
        go = 1'b1;
        kind = k;
        addr = a;
        @(negedge clk);
    endtask
    // Assist writes back to back, readback, then the write-entry pulse
    task automatic load(input logic [31:0] v0, v1, v2, v3);
        logic [63:0] w [4];
        w = '{{32'($random(seed)), v0}, {32'($random(seed)), v1},
            {32'($random(seed)), v2}, {32'($random(seed)), v3}};
        go = 1'b0;
        for (int n = 0; n < 4; n++) begin
            ar_we = 1'b1;
            ar_sel = 2'(n);
            ar_wdata = w[n];
            @(negedge clk);
        end
        ar_we = 1'b0;
        for (int n = 0; n < 4; n++) begin
            ar_sel = 2'(n);
            #1 cmp_reg(w[n], ar_rdata);
        end
        @(negedge clk);
        wr_entry = 1'b1;
        @(negedge clk);
        wr_entry = 1'b0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Result watcher: oldest note against each result that appears
    always @(negedge clk) begin
        if (res_valid !== 1'b0 || res_miss !== 1'b0) begin
            if (q.size() == 0) begin
                failures++;
                $display("[FAIL] %0t exp %h got %h", $time, 0, res_raddr);
            end else begin
                cmp_res(q[0], '{res_valid, res_miss, res_raddr,
                    res_inh, res_perm, res_route});
                void'(q.pop_front());
            end
        end
    end

    // Hang guard at 3000 cycles, far beyond the 80 or so cycles the run needs
    initial begin
        #(40 * 3000);
        failures++;
        report_and_stop();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] a;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        acc(0, MMUTB_CPU, 32'hFFFF_FABC, 32'hFFFF_FABC, 1, 6'h3F, 2);
        acc(1, MMUTB_CPU, 32'hFFFF_EFFC, 0, 0, 0, 0);
        load(32'h1001_0000, 32'h8000_0800, 32'hE000_0008, 32'h4000_003F);
        acc(0, MMUTB_CPU, 32'hE3FF_FFFC, 32'h43FF_FFFC, 1, 6'h3F, 2);
        acc(0, MMUTB_CPU, 32'hE000_0000, 32'h4000_0000, 1, 6'h3F, 2);
        acc(1, MMUTB_CPU, 32'hE400_0000, 0, 0, 0, 0);
        load(32'h1002_0000, 32'h8000_0100, 32'h5000_0000, 32'h6000_003F);
        acc(0, MMUTB_CPU, 32'h5000_0FFF, 32'h6000_0FFF, 0, 6'h3F, 2);
        acc(1, MMUTB_CPU, 32'h5000_1000, 0, 0, 0, 0);
        load(32'h100F_0000, 32'h8000_0900, 32'h0000_0000, 32'h0000_0015);
        for (int n = 0; n < 6; n++) begin
            a = 32'($random(seed)) & 32'h0FFF_FFFF;
            acc(0, 2'($unsigned($random(seed)) % 3), a, a, 0, 6'h15, 2);
        end
        acc(1, MMUTB_CPU, 32'h1000_0000, 0, 0, 0, 0);
        // Fixed array: two ways of one set, third write evicts the first
        load(32'h0000_0000, 32'h8000_0100, 32'h2000_0000, 32'h7000_0015);
        load(32'h0000_0000, 32'h8000_0100, 32'h2008_0008, 32'h7100_002A);
        acc(0, MMUTB_CPU, 32'h2000_0ABC, 32'h7000_0ABC, 0, 6'h15, 2);
        acc(0, MMUTB_CPU, 32'h2008_0ABC, 32'h7100_0ABC, 1, 6'h2A, 2);
        acc(1, MMUTB_CPU, 32'h2000_1ABC, 0, 0, 0, 0);
        load(32'h0000_0000, 32'h8000_0100, 32'h2010_0000, 32'h7200_0015);
        acc(1, MMUTB_CPU, 32'h2000_0010, 0, 0, 0, 0);
        acc(0, MMUTB_CPU, 32'h2008_0010, 32'h7100_0010, 1, 6'h2A, 2);
        acc(0, MMUTB_CPU, 32'h2010_0010, 32'h7200_0010, 0, 6'h15, 2);
        // SRAM window at zero, kept clear of config space
        sram_en = 1'b1;
        acc(0, MMUTB_CPU, 32'h0001_0000, 32'h0001_0000, 0, 6'h15, 1);
        acc(0, MMUTB_CPU, 32'h0003_F000, 32'h0003_F000, 0, 6'h15, 2);
        sram_256k = 1'b1;
        acc(0, MMUTB_CPU, 32'h0003_F000, 32'h0003_F000, 0, 6'h15, 1);
        acc(0, MMUTB_IO_SNOOP, 32'h0003_F000, 32'h0003_F000, 0, 6'h15, 1);
        acc(0, MMUTB_IO_PLAIN, 32'h0003_F000, 32'h0003_F000, 0, 6'h15, 2);
        law_hit = 1'b0;
        acc(0, MMUTB_IO_PLAIN, 32'h0000_0040, 32'h0000_0040, 0, 6'h15, 0);
        law_hit = 1'b1;
        // Window moved off zero: precedence follows the base
        sram_base = 32'h0004_0000;
        acc(0, MMUTB_CPU, 32'h0007_F000, 32'h0007_F000, 0, 6'h15, 1);
        acc(0, MMUTB_CPU, 32'h0003_F000, 32'h0003_F000, 0, 6'h15, 2);
        cfg_base = 32'h0010_0000;
        acc(0, MMUTB_CPU, 32'h0010_0040, 32'h0010_0040, 0, 6'h15, 3);
        // Second reset mid-run: mapped entries drop, boot page returns
        go = 1'b0;
        repeat (2) @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        acc(1, MMUTB_CPU, 32'h0001_0000, 0, 0, 0, 0);
        acc(0, MMUTB_CPU, 32'hFFFF_F000, 32'hFFFF_F000, 1, 6'h3F, 2);
        go = 1'b0;
        repeat (3) @(negedge clk);
        if (q.size() != 0) begin
            failures++;
            $display("[FAIL] %0t exp %h got %h", $time, 0, q.size());
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
